// [src/gpc_pkg.sv]
// Constants used by the pin control slice; its synchroniser uses none of them.
package gpc_pkg;

    // ************************************************************
    // Register bus and map
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_PIN_CONTROL_PRIMARY = 12'h000;
    localparam logic [11:0] OFF_GROUP_OUTPUT = 12'h004;
    localparam int GROUP_OUT_BIT = 0;

    // ************************************************************
    // Field positions of the pin control word
    // ************************************************************
    localparam int BIT_PAD_IN = 24;
    localparam int BIT_OUT_DATA = 16;
    localparam int BIT_IN_DISABLE = 15;
    localparam int MUX_HI = 13;
    localparam int MUX_LO = 12;
    localparam int BIT_OUT_SELECT = 10;
    localparam int BIT_DIRECTION = 9;
    localparam int PGS_HI = 3;
    localparam int PGS_LO = 2;

    // Bits that hold state or live data; every other bit reads as zero.
    localparam logic [31:0] CTL_READ_MASK = 32'h0101_b60c;

    // ************************************************************
    // Field encodings and reset values
    // ************************************************************
    localparam logic [1:0] MUX_GPIO = 2'h0;
    localparam logic [1:0] MUX_ALT1 = 2'h1;
    localparam logic [1:0] MUX_ALT2 = 2'h2;
    localparam logic [1:0] MUX_ALT3 = 2'h3;
    localparam logic OSEL_SINGLE = 1'h0;
    localparam logic OSEL_GROUP = 1'h1;

    localparam logic [1:0] RST_MUX = 2'h0;
    localparam logic RST_IN_DISABLE = 1'h0;
    localparam logic RST_OUT_SELECT = 1'h0;
    localparam logic RST_DIRECTION = 1'h0;
    localparam logic [1:0] RST_PGS = 2'h0;
    localparam logic RST_OUT_DATA = 1'h0;

    // Default number of power wells that the gating select can name.
    localparam int WELL_COUNT_DEFAULT = 4;

endpackage

// [src/gpc_sync.sv]
// Two-stage synchroniser for levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module gpc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

// [src/gpc_pin_ctrl.sv]
// Pin control register slice for one general purpose I/O pin.
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_ctrl #(
    parameter int WELL_COUNT = gpc_pkg::WELL_COUNT_DEFAULT
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic [gpc_pkg::ADDR_W-1:0] ADDR,
    input wire logic [gpc_pkg::DATA_W-1:0] WDATA,
    input wire logic WR_STB,
    input wire logic RD_STB,
    output logic [gpc_pkg::DATA_W-1:0] RDATA,
    input wire logic PAD_IN,
    input wire logic [WELL_COUNT-1:0] PWR_WELL_ON,
    input wire logic [2:0] ALT_OUT,
    input wire logic [2:0] ALT_OE,
    output logic PAD_OUT,
    output logic PAD_OE,
    output logic PAD_IE,
    output logic PAD_IN_LIVE
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The two-bit gating select can name at most four wells.
    if (WELL_COUNT < 1 || WELL_COUNT > 4) begin : g_bad_well_count
        $error("WELL_COUNT must lie between 1 and 4");
    end

    // ************************************************************
    // Pin level and power well synchronisers
    // ************************************************************
    logic pad_level;
    logic [WELL_COUNT-1:0] well_on_sync;

    gpc_sync #(.WIDTH(1)) u_pad_sync (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .async_in(PAD_IN),
        .sync_out(pad_level)
    );

    gpc_sync #(.WIDTH(WELL_COUNT)) u_well_sync (
        .CLK_SYS(CLK_SYS),
        .RST(RST),
        .async_in(PWR_WELL_ON),
        .sync_out(well_on_sync)
    );

    // ************************************************************
    // Register state
    // ************************************************************
    logic [1:0] mux;
    logic in_disable;
    logic out_select;
    logic direction;
    logic [1:0] power_well_gating_select;
    logic out_single;
    logic out_group;

    // ************************************************************
    // Address decode and write qualification
    // ************************************************************
    wire hit_ctl = (ADDR == gpc_pkg::OFF_PIN_CONTROL_PRIMARY);
    wire hit_grp = (ADDR == gpc_pkg::OFF_GROUP_OUTPUT);
    wire wr_ctl = WR_STB && hit_ctl;
    wire wr_grp = WR_STB && hit_grp;
    // The source select in force before the write decides which data bit
    // is open, so a write that sets bit 10 still writes bit 16 and one that clears it does not.
    wire single_open = (out_select == gpc_pkg::OSEL_SINGLE);
    wire wr_single = wr_ctl && single_open;
    wire wr_group = wr_grp && !single_open;

    wire next_out_single = wr_single ? WDATA[gpc_pkg::BIT_OUT_DATA] : out_single;
    wire next_out_group = wr_group ? WDATA[gpc_pkg::GROUP_OUT_BIT] : out_group;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            mux <= gpc_pkg::RST_MUX;
            in_disable <= gpc_pkg::RST_IN_DISABLE;
            out_select <= gpc_pkg::RST_OUT_SELECT;
            direction <= gpc_pkg::RST_DIRECTION;
            power_well_gating_select <= gpc_pkg::RST_PGS;
        end else if (wr_ctl) begin
            mux <= WDATA[gpc_pkg::MUX_HI:gpc_pkg::MUX_LO];
            in_disable <= WDATA[gpc_pkg::BIT_IN_DISABLE];
            out_select <= WDATA[gpc_pkg::BIT_OUT_SELECT];
            direction <= WDATA[gpc_pkg::BIT_DIRECTION];
            power_well_gating_select <= WDATA[gpc_pkg::PGS_HI:gpc_pkg::PGS_LO];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            out_single <= gpc_pkg::RST_OUT_DATA;
            out_group <= gpc_pkg::RST_OUT_DATA;
        end else begin
            out_single <= next_out_single;
            out_group <= next_out_group;
        end
    end

    // ************************************************************
    // Input path
    // ************************************************************
    // A select naming a well beyond WELL_COUNT is treated as a dead well.
    wire [3:0] well_vec = 4'({well_on_sync});
    wire well_on = well_vec[power_well_gating_select];
    // With the well off the buffer output is undefined, so it is forced high.
    wire in_bit = !well_on ? 1'b1 : (in_disable ? 1'b0 : pad_level);

    // ************************************************************
    // Output path
    // ************************************************************
    wire gpio_data = single_open ? out_single : out_group;
    wire [3:0] out_vec = {ALT_OUT, gpio_data};
    wire [3:0] oe_vec = {ALT_OE, direction};
    wire next_pad_out = out_vec[mux];
    wire next_pad_oe = oe_vec[mux];

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PAD_OUT <= gpc_pkg::RST_OUT_DATA;
            PAD_OE <= gpc_pkg::RST_DIRECTION;
            PAD_IE <= !gpc_pkg::RST_IN_DISABLE;
            PAD_IN_LIVE <= 1'b0;
        end else begin
            PAD_OUT <= next_pad_out;
            PAD_OE <= next_pad_oe;
            PAD_IE <= !in_disable;
            PAD_IN_LIVE <= in_bit;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    logic [31:0] ctl_word;

    always_comb begin
        ctl_word = 32'h0000_0000;
        ctl_word[gpc_pkg::BIT_PAD_IN] = in_bit;
        ctl_word[gpc_pkg::BIT_OUT_DATA] = out_single;
        ctl_word[gpc_pkg::BIT_IN_DISABLE] = in_disable;
        ctl_word[gpc_pkg::MUX_HI:gpc_pkg::MUX_LO] = mux;
        ctl_word[gpc_pkg::BIT_OUT_SELECT] = out_select;
        ctl_word[gpc_pkg::BIT_DIRECTION] = direction;
        ctl_word[gpc_pkg::PGS_HI:gpc_pkg::PGS_LO] = power_well_gating_select;
    end

    wire [31:0] grp_word = {31'h0000_0000, out_group};
    // Bits that the addressed word may carry; the grouped word owns only its data bit.
    wire [31:0] grp_mask = 32'h0000_0001 << gpc_pkg::GROUP_OUT_BIT;
    wire [31:0] rd_mask = hit_ctl ? gpc_pkg::CTL_READ_MASK : (hit_grp ? grp_mask : 32'h0000_0000);
    wire [31:0] sel_word = hit_ctl ? ctl_word : (hit_grp ? grp_word : 32'h0000_0000);
    wire [31:0] next_rdata = RD_STB ? sel_word : 32'h0000_0000;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);

    AST_PAD_BIT_LIVE: assert property (
        (RD_STB && hit_ctl && well_on && !in_disable)
        |=> (RDATA[gpc_pkg::BIT_PAD_IN] == $past(pad_level)))
        else $error("Pad input bit does not follow the pad level");

    AST_WELL_OFF_HIGH: assert property (
        (RD_STB && hit_ctl && !well_on)
        |=> RDATA[gpc_pkg::BIT_PAD_IN])
        else $error("Pad input bit not high with its well off");

    AST_SINGLE_DRIVES_PIN: assert property (
        (wr_ctl && single_open
            && (WDATA[gpc_pkg::MUX_HI:gpc_pkg::MUX_LO] == gpc_pkg::MUX_GPIO)
            && !WDATA[gpc_pkg::BIT_OUT_SELECT] && WDATA[gpc_pkg::BIT_DIRECTION])
        ##1 !WR_STB
        |=> (PAD_OUT == $past(WDATA[gpc_pkg::BIT_OUT_DATA], 2)) && PAD_OE)
        else $error("Single output bit did not reach the pin");

    AST_SINGLE_LOCKED: assert property (
        (wr_ctl && !single_open) |=> $stable(out_single))
        else $error("Single output bit changed while grouped source selected");

    AST_READBACK: assert property (
        (RD_STB && hit_ctl)
        |=> (RDATA[gpc_pkg::BIT_OUT_DATA] == $past(out_single)))
        else $error("Output data bit does not read back the programmed value");

    AST_INPUT_BLOCKED: assert property (
        (in_disable && well_on) |=> (!PAD_IE && !PAD_IN_LIVE))
        else $error("Input path not blocked while disabled");

    AST_MUX_ALT2: assert property (
        (mux == gpc_pkg::MUX_ALT2) |=> (PAD_OUT == $past(ALT_OUT[1])))
        else $error("Function two output not routed to the pin");

    AST_GROUP_LOCKED: assert property (
        (wr_grp && single_open) |=> $stable(out_group))
        else $error("Grouped output bit changed while single source selected");

    AST_DIR_ALT3: assert property (
        (mux == gpc_pkg::MUX_ALT3) |=> (PAD_OE == $past(ALT_OE[2])))
        else $error("Function three does not own the pin direction");

    AST_DIR_GPIO: assert property (
        (mux == gpc_pkg::MUX_GPIO) |=> (PAD_OE == $past(direction)))
        else $error("Direction bit does not steer the buffer under GPIO");

    AST_RESERVED_ZERO: assert property (
        RD_STB |=> ((RDATA & ~$past(rd_mask)) == 32'h0000_0000))
        else $error("Reserved bits read as nonzero");

    COV_SINGLE_WRITE: cover property (wr_single ##2 PAD_OE);
    COV_GROUP_WRITE: cover property (wr_group ##1 (out_group != out_single));
    COV_ALT1_ACTIVE: cover property ((mux == gpc_pkg::MUX_ALT1) ##1 PAD_OE);
    COV_WELL_OFF_READ: cover property (RD_STB && hit_ctl && !well_on);

endmodule

`default_nettype wire

// [testbench/gpc_pad_model.sv]
// Pad and alternate function model on the far side of the pin slice.
`timescale 1ns/1ps
`default_nettype none

module gpc_pad_model (
    input wire logic CLK_SYS,
    input wire logic ext_level,
    input wire logic [2:0] alt_val,
    input wire logic [2:0] alt_en,
    input wire logic PAD_OUT,
    input wire logic PAD_OE,
    output logic PAD_IN,
    output logic [2:0] ALT_OUT,
    output logic [2:0] ALT_OE
);
    // The driven level wins over the weak outside source, so a read of the
    // pad shows the pin, not the programmed data bit.
    assign PAD_IN = PAD_OE ? PAD_OUT : ext_level;

    // Alternate functions are on-chip logic launched from the same clock.
    always_ff @(posedge CLK_SYS) begin
        ALT_OUT <= alt_val;
        ALT_OE <= alt_en;
    end
endmodule

`default_nettype wire

// [testbench/gpc_pin_ctrl_tb_top.sv]
// Self-checking bench for the pin control slice.
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_ctrl_tb_top;
    localparam int WC = 3;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic [11:0] ADDR = 12'h000;
    logic [31:0] WDATA = 32'h0000_0000;
    logic WR_STB = 1'b0;
    logic RD_STB = 1'b0;
    logic [31:0] RDATA;
    logic PAD_IN;
    logic [WC-1:0] PWR_WELL_ON = 3'h7;
    logic [2:0] ALT_OUT;
    logic [2:0] ALT_OE;
    logic PAD_OUT;
    logic PAD_OE;
    logic PAD_IE;
    logic PAD_IN_LIVE;
    logic ext_level = 1'b0;
    logic [2:0] alt_val = 3'h0;
    logic [2:0] alt_en = 3'h0;
    logic [31:0] ctl = 32'h0000_0000;
    logic grp = 1'b0;
    logic [31:0] seed = 32'h0000_0032;
    logic [31:0] rd_val;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    always #12.5 CLK_SYS = ~CLK_SYS;

    gpc_pin_ctrl #(.WELL_COUNT(WC)) dut_u (.CLK_SYS(CLK_SYS), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .PAD_IN(PAD_IN),
        .PWR_WELL_ON(PWR_WELL_ON), .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE), .PAD_OUT(PAD_OUT),
        .PAD_OE(PAD_OE), .PAD_IE(PAD_IE), .PAD_IN_LIVE(PAD_IN_LIVE));

    gpc_pad_model pad_u (.CLK_SYS(CLK_SYS), .ext_level(ext_level), .alt_val(alt_val),
        .alt_en(alt_en), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_IN(PAD_IN),
        .ALT_OUT(ALT_OUT), .ALT_OE(ALT_OE));

    // ************************************************************
    // Expectations and bus tasks
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic exp_oe();
        return (ctl[13:12] == 2'h0) ? ctl[9] : alt_en[ctl[13:12] - 2'h1];
    endfunction

    function automatic logic exp_out();
        if (ctl[13:12] != 2'h0) return alt_val[ctl[13:12] - 2'h1];
        return ctl[10] ? grp : ctl[16];
    endfunction

    // A gating select beyond the wells present counts as a well that is off.
    function automatic logic exp_live();
        if (int'(ctl[3:2]) >= WC || !PWR_WELL_ON[ctl[3:2]]) return 1'b1;
        if (ctl[15]) return 1'b0;
        return exp_oe() ? exp_out() : ext_level;
    endfunction

    task automatic results();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= d;
        WR_STB <= 1'b1;
        @(posedge CLK_SYS);
        WR_STB <= 1'b0;
        if (a == 12'h004 && ctl[10]) grp = d[0];
        if (a == 12'h000) ctl = (d & 32'h0000_b60c) | ((ctl[10] ? ctl : d) & 32'h0001_0000);
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD_STB <= 1'b1;
        @(posedge CLK_SYS);
        RD_STB <= 1'b0;
        #1 rd_val = RDATA;
    endtask

    // Waits long enough for the pin loop back through both synchronisers.
    task automatic audit();
        repeat (6) @(posedge CLK_SYS);
        rd(12'h000);
        chk(rd_val & 32'hfefe_4000, 32'h0);
        chk(rd_val & 32'h0000_b60c, ctl & 32'h0000_b60c);
        chk({31'h0, rd_val[16]}, {31'h0, ctl[16]});
        chk({31'h0, rd_val[24]}, {31'h0, exp_live()});
        chk({31'h0, PAD_IN_LIVE}, {31'h0, exp_live()});
        chk({31'h0, PAD_IE}, {31'h0, ~ctl[15]});
        chk({31'h0, PAD_OE}, {31'h0, exp_oe()});
        if (exp_oe()) chk({31'h0, PAD_OUT}, {31'h0, exp_out()});
        rd(12'h004);
        chk(rd_val, {31'h0, grp});
    endtask

    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            results();
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (11) @(posedge CLK_SYS);
        #1 chk({RDATA[30:0], PAD_IE}, 32'h1);
        @(posedge CLK_SYS);
        RST <= 1'b0;
        audit();
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            alt_val <= 3'(m) ^ 3'h5;
            alt_en <= 3'(m) ^ 3'h3;
            wr(12'h000, 32'h0001_0200 | (32'(m) << 12));
            audit();
        end
        $display("test mux done");
        // Source select takes effect from its old value, so order matters here.
        wr(12'h000, 32'h0000_0600);
        wr(12'h000, 32'h0001_0600);
        audit();
        wr(12'h004, 32'h0000_0001);
        audit();
        wr(12'h000, 32'h0000_0200);
        audit();
        $display("test source done");
        @(posedge CLK_SYS);
        PWR_WELL_ON <= 3'h5;
        wr(12'h000, 32'h0000_8004);
        audit();
        wr(12'h000, 32'h0000_800c);
        audit();
        @(posedge CLK_SYS);
        PWR_WELL_ON <= 3'h7;
        wr(12'h000, 32'hffff_ffff);
        audit();
        wr(12'h008, 32'hffff_ffff);
        rd(12'h008);
        chk(rd_val, 32'h0);
        audit();
        $display("test corner done");
        repeat (80) begin
            seed = xs(seed);
            @(posedge CLK_SYS);
            ext_level <= seed[31];
            alt_val <= seed[30:28];
            alt_en <= seed[27:25];
            PWR_WELL_ON <= seed[22:20] | seed[19:17];
            wr(seed[6] ? 12'h004 : 12'h000, xs(seed));
            audit();
        end
        $display("test random done");
        results();
    end
endmodule

`default_nettype wire
